// *** rtl/pvaip_pkg.sv ***
package pvaip_pkg;
  localparam int PIX_W         = 24;
  localparam int AUD_PINS      = 4;
  localparam int GPIO_N        = 6;
  localparam int SYNC_W        = 32;
  localparam int WORD_W        = 31;
  localparam int FIFO_DEPTH    = 8;
  localparam int FIFO_AW       = 3;
  // Pin positions inside the synchroniser vector
  localparam int SB_LINE       = 24;
  localparam int SB_FRAME      = 25;
  localparam int SB_ACTIVE     = 26;
  localparam int SB_PCLK       = 27;
  localparam int SB_AUD        = 28;
  // Audio pin order: 0 second data, 1 first data, 2 word clock, 3 audio clock
  localparam int AUD_B         = 0;
  localparam int AUD_A         = 1;
  localparam int AUD_WC        = 2;
  localparam int AUD_CLK       = 3;
  localparam int PIX_B17       = 17;
  // Field positions in a FIFO word
  localparam int WF_LINE       = 24;
  localparam int WF_FRAME      = 25;
  localparam int WF_ACTIVE     = 26;
  localparam int WF_AUD        = 27;
  // Control filter and source limits, in pixel clocks
  localparam int FILT_MIN_PCLK = 3;
  localparam int CTL_TOGGLE_MAX = 2;
  localparam int CTL_WIN_PCLK  = 130;
  localparam logic [1:0] FILT_LAST = 2'(FILT_MIN_PCLK - 1);
  localparam int GPIO_BIT [GPIO_N] = '{0, 1, 8, 9, 16, 17};
endpackage

// *** rtl/pvaip_port.sv ***
`timescale 1ns/1ps

module pvaip_fifo #(
  parameter int W  = 31,
  parameter int D  = 8,
  parameter int AW = 3
) (
  input  wire logic          clk_sys,
  input  wire logic          sys_rst,
  input  wire logic          s_valid,
  output logic               s_ready,
  input  wire logic [W-1:0]  s_data,
  output logic               m_valid,
  input  wire logic          m_ready,
  output logic [W-1:0]       m_data
);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wr;
    logic [AW-1:0]       rd;
    logic [AW:0]         cnt;
    logic                vld;
    logic [W-1:0]        dout;
  } pvaip_fifo_s;

  pvaip_fifo_s st_r;
  pvaip_fifo_s st_nxt;
  logic        push;
  logic        pop;

  localparam logic [AW:0] FULL_CNT = (AW+1)'(D);

  assign s_ready = (st_r.cnt != FULL_CNT);
  // Valid and word are flopped copies so the link side sees registers only
  assign m_valid = st_r.vld;
  assign m_data  = st_r.dout;
  assign push    = s_valid && s_ready;
  assign pop     = m_valid && m_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wr] = s_data;
      st_nxt.wr = st_r.wr + 1'b1;
    end
    if (pop) begin
      st_nxt.rd = st_r.rd + 1'b1;
    end
    case ({push, pop})
      2'h2:    st_nxt.cnt = st_r.cnt + 1'h1;
      2'h1:    st_nxt.cnt = st_r.cnt - 1'h1;
      default: st_nxt.cnt = st_r.cnt;
    endcase
    st_nxt.vld  = (st_nxt.cnt != '0);
    st_nxt.dout = st_nxt.mem[st_nxt.rd];
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // pvaip_fifo

module pvaip_port (
  input  wire logic                           clk_sys,
  input  wire logic                           sys_rst,
  input  wire logic [pvaip_pkg::PIX_W-1:0]    pix_in,
  input  wire logic                           line_sync,
  input  wire logic                           frame_sync,
  input  wire logic                           active_video_flag,
  input  wire logic                           pclk_in,
  input  wire logic [pvaip_pkg::AUD_PINS-1:0] aud_pin_i,
  output logic      [pvaip_pkg::AUD_PINS-1:0] aud_pin_o,
  output logic      [pvaip_pkg::AUD_PINS-1:0] aud_pin_oe,
  input  wire logic                           strobe_edge_select,
  input  wire logic                           ctl_filter_en,
  input  wire logic                           color18_mode,
  input  wire logic                           pix17_from_aud,
  input  wire logic [pvaip_pkg::GPIO_N-1:0]   gpio_en,
  output logic      [pvaip_pkg::GPIO_N-1:0]   gpio_level,
  input  wire logic [pvaip_pkg::AUD_PINS-1:0] register_driven_output_en,
  input  wire logic [pvaip_pkg::AUD_PINS-1:0] register_driven_output,
  output logic                                overflow,
  output logic                                link_valid,
  input  wire logic                           link_ready,
  output logic      [pvaip_pkg::WORD_W-1:0]   link_data
);
  typedef struct packed {
    logic [pvaip_pkg::SYNC_W-1:0]   s1;
    logic [pvaip_pkg::SYNC_W-1:0]   s2;
    logic [pvaip_pkg::SYNC_W-1:0]   s3;
    logic [pvaip_pkg::SYNC_W-1:0]   stab;
    logic                           pclk_q;
    logic [1:0]                     line_cnt;
    logic [1:0]                     act_cnt;
    logic                           line_f;
    logic                           act_f;
    logic [pvaip_pkg::GPIO_N-1:0]   gpio;
    logic [pvaip_pkg::AUD_PINS-1:0] aud_o;
    logic [pvaip_pkg::AUD_PINS-1:0] aud_oe;
    logic                           ovf;
  } pvaip_top_s;

  pvaip_top_s                   st_r;
  pvaip_top_s                   st_nxt;
  logic                         strobe;
  logic                         fifo_ready;
  logic [pvaip_pkg::WORD_W-1:0] word;

  always_comb begin
    logic [pvaip_pkg::PIX_W-1:0]    pix;
    logic [pvaip_pkg::AUD_PINS-1:0] aud;
    logic                           line_s;
    logic                           act_s;
    pix    = '0;
    aud    = '0;
    line_s = 1'b0;
    act_s  = 1'b0;
    st_nxt = st_r;
    // Three-stage capture; a bit counts once stages two and three agree
    st_nxt.s1 = {aud_pin_i, pclk_in, active_video_flag, frame_sync, line_sync, pix_in};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.stab = (st_r.s2 & st_r.s3) | (st_r.stab & (st_r.s2 ^ st_r.s3));
    st_nxt.pclk_q = st_r.stab[pvaip_pkg::SB_PCLK];
    strobe = strobe_edge_select ? (st_r.pclk_q && !st_r.stab[pvaip_pkg::SB_PCLK])
                                : (!st_r.pclk_q && st_r.stab[pvaip_pkg::SB_PCLK]);

    pix = st_r.stab[pvaip_pkg::PIX_W-1:0];
    for (int i = 0; i < pvaip_pkg::GPIO_N; i++) begin
      st_nxt.gpio[i] = gpio_en[i] && st_r.stab[pvaip_pkg::GPIO_BIT[i]];
      if (gpio_en[i]) begin
        pix[pvaip_pkg::GPIO_BIT[i]] = 1'b0;
      end
    end
    aud = st_r.stab[pvaip_pkg::SB_AUD +: pvaip_pkg::AUD_PINS] & ~register_driven_output_en;
    if (pix17_from_aud) begin
      pix[pvaip_pkg::PIX_B17] = aud[pvaip_pkg::AUD_B];
    end
    if (!color18_mode || pix17_from_aud) begin
      aud[pvaip_pkg::AUD_B] = 1'b0;
    end

    // Driven pins never feed the audio capture
    st_nxt.aud_o  = register_driven_output & register_driven_output_en;
    st_nxt.aud_oe = register_driven_output_en;

    line_s = st_r.stab[pvaip_pkg::SB_LINE];
    act_s  = st_r.stab[pvaip_pkg::SB_ACTIVE];
    if (strobe) begin
      if (!ctl_filter_en) begin
        st_nxt.line_f   = line_s;
        st_nxt.act_f    = act_s;
        st_nxt.line_cnt = '0;
        st_nxt.act_cnt  = '0;
      end else begin
        if (line_s == st_r.line_f) begin
          st_nxt.line_cnt = '0;
        end else if (st_r.line_cnt == pvaip_pkg::FILT_LAST) begin
          st_nxt.line_f   = line_s;
          st_nxt.line_cnt = '0;
        end else begin
          st_nxt.line_cnt = st_r.line_cnt + 1'b1;
        end
        if (act_s == st_r.act_f) begin
          st_nxt.act_cnt = '0;
        end else if (st_r.act_cnt == pvaip_pkg::FILT_LAST) begin
          st_nxt.act_f   = act_s;
          st_nxt.act_cnt = '0;
        end else begin
          st_nxt.act_cnt = st_r.act_cnt + 1'b1;
        end
      end
      if (!fifo_ready) begin
        st_nxt.ovf = 1'b1;
      end
    end

    word = {aud, st_nxt.act_f, st_r.stab[pvaip_pkg::SB_FRAME], st_nxt.line_f, pix};
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  pvaip_fifo #(
    .W  (pvaip_pkg::WORD_W),
    .D  (pvaip_pkg::FIFO_DEPTH),
    .AW (pvaip_pkg::FIFO_AW)
  ) u_fifo (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .s_valid (strobe),
    .s_ready (fifo_ready),
    .s_data  (word),
    .m_valid (link_valid),
    .m_ready (link_ready),
    .m_data  (link_data)
  );

  assign gpio_level = st_r.gpio;
  assign aud_pin_o  = st_r.aud_o;
  assign aud_pin_oe = st_r.aud_oe;
  assign overflow   = st_r.ovf;
endmodule // pvaip_port

// *** verif/pvaip_src.sv ***
`timescale 1ns/1ps
module pvaip_src (
  input  logic        clk_sys,
  output logic [23:0] pix_in,
  output logic        line_sync,
  output logic        frame_sync,
  output logic        active_video_flag,
  output logic        pclk_in
);
  initial {pix_in, line_sync, frame_sync, active_video_flag, pclk_in} = '0;
  // Pins lead the rising pixel clock edge by 5 cycles and the falling edge by 10 cycles
  task automatic send(input logic [23:0] d, input logic [2:0] c);
    @(negedge clk_sys);
    pix_in = d;
    {active_video_flag, frame_sync, line_sync} = c;
    repeat (5) @(negedge clk_sys);
    pclk_in = 1'b1;
    repeat (5) @(negedge clk_sys);
    pclk_in = 1'b0;
    repeat (8) @(negedge clk_sys);
  endtask
endmodule // pvaip_src

// *** verif/pvaip_port_properties.sv ***
`timescale 1ns/1ps
module pvaip_port_properties (
  input logic        clk_sys,
  input logic        sys_rst,
  input logic        pclk_in,
  input logic        strobe_edge_select,
  input logic [3:0]  register_driven_output_en,
  input logic [3:0]  register_driven_output,
  input logic [3:0]  aud_pin_o,
  input logic [3:0]  aud_pin_oe,
  input logic [5:0]  gpio_en,
  input logic [5:0]  gpio_level,
  input logic        overflow,
  input logic        link_valid,
  input logic        link_ready,
  input logic [30:0] link_data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  oe_delay_a:
    assert property (!$past(sys_rst) |-> aud_pin_oe == $past(register_driven_output_en))
    else $error("drive enable wrong");
  out_level_a:
    assert property (!$past(sys_rst) |-> (aud_pin_o & aud_pin_oe) ==
      ($past(register_driven_output) & aud_pin_oe)) else $error("output level wrong");
  gpio_off_a:
    assert property (!$past(sys_rst) |-> (gpio_level & ~$past(gpio_en)) == 6'h00)
    else $error("gpio level while off");
  word_hold_a:
    assert property (link_valid && !link_ready |=> link_valid && $stable(link_data))
    else $error("word not held");
  ovf_keep_a: assert property (overflow |=> overflow) else $error("overflow lost");
  ovf_cause_a:
    assert property ($rose(overflow) |-> $past(link_valid)) else $error("overflow not full");
  rise_strobe_a:
    assert property ($rose(pclk_in) && !strobe_edge_select && !link_valid |-> ##[3:6]
      link_valid) else $error("no rising strobe");
  fall_strobe_a:
    assert property ($fell(pclk_in) && strobe_edge_select && !link_valid |-> ##[3:6]
      link_valid) else $error("no falling strobe");
endmodule // pvaip_port_properties
bind pvaip_port pvaip_port_properties chk (.clk_sys, .sys_rst, .pclk_in, .strobe_edge_select,
  .register_driven_output_en, .register_driven_output, .aud_pin_o, .aud_pin_oe, .gpio_en,
  .gpio_level, .overflow, .link_valid, .link_ready, .link_data);

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [23:0] pix_in;
  logic [3:0]  aud_pin_i = 4'h0, aud_pin_o, aud_pin_oe, rdo_en = 4'h0, rdo = 4'h0;
  logic [5:0]  gpio_en = 6'h00, gpio_level;
  logic [30:0] link_data, got[$];
  logic        line_sync, frame_sync, active_video_flag, pclk_in, overflow, link_valid;
  logic        sel = 1'b0, filt = 1'b0, c18 = 1'b0, p17 = 1'b0, rdy = 1'b1;
  int          bad_count = 0, total_checks = 0, cyc = 0;
  always #10 clk_sys = ~clk_sys;
  pvaip_src src (.clk_sys, .pix_in, .line_sync, .frame_sync, .active_video_flag, .pclk_in);
  pvaip_port uut (.clk_sys, .sys_rst, .pix_in, .line_sync, .frame_sync, .active_video_flag,
    .pclk_in, .aud_pin_i, .aud_pin_o, .aud_pin_oe, .strobe_edge_select(sel),
    .ctl_filter_en(filt), .color18_mode(c18), .pix17_from_aud(p17), .gpio_en, .gpio_level,
    .register_driven_output_en(rdo_en), .register_driven_output(rdo), .overflow,
    .link_valid, .link_ready(rdy), .link_data);
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (link_valid === 1'b1 && rdy === 1'b1) got.push_back(link_data);
    if (cyc == 30000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [30:0] g, input logic [30:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wd(input logic [30:0] e);
    chk(got.size() > 0 ? got.pop_front() : 'x, e);
  endtask
  task automatic quiet(input logic [2:0] c);
    repeat (130) src.send(24'h0, c);
    got.delete();
  endtask
  task automatic t_edge;
    for (int s = 0; s < 2; s++) begin
      sel = s[0];
      src.send(24'hA5C33C, 3'h2);
      wd({4'h0, 3'h2, 24'hA5C33C});
    end
  endtask
  task automatic t_raw;
    src.send(24'h000011, 3'h7);
    src.send(24'h000022, 3'h2);
    wd({4'h0, 3'h7, 24'h000011});
    wd({4'h0, 3'h2, 24'h000022});
    quiet(3'h2);
  endtask
  task automatic t_filt;
    logic [2:0] in_c [9] = '{3'h7, 3'h7, 3'h2, 3'h7, 3'h7, 3'h7, 3'h2, 3'h2, 3'h2};
    logic [2:0] ex_c [9] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h7, 3'h7, 3'h7, 3'h2};
    filt = 1'b1;
    for (int i = 0; i < 9; i++) begin
      src.send(24'(i), in_c[i]);
      if (i % 3 == 2) begin
        for (int k = i - 2; k <= i; k++) wd({4'h0, ex_c[k], 24'(k)});
        quiet(in_c[i]);
      end
    end
  endtask
  task automatic t_gpio;
    gpio_en = 6'h3F;
    src.send(24'hFFFFFF, 3'h2);
    chk(31'(gpio_level), 31'h3F);
    wd({4'h0, 3'h2, 24'hFCFCFC});
    gpio_en = 6'h00;
  endtask
  task automatic t_aud;
    rdo_en = 4'hF;
    rdo = 4'hA;
    aud_pin_i = 4'hF;
    src.send(24'h0, 3'h2);
    chk(31'({aud_pin_oe, aud_pin_o}), 31'hFA);
    wd({4'h0, 3'h2, 24'h0});
    rdo_en = 4'h0;
    c18 = 1'b1;
    src.send(24'h0, 3'h2);
    wd({4'hF, 3'h2, 24'h0});
    p17 = 1'b1;
    src.send(24'h0, 3'h2);
    wd({4'hE, 3'h2, 24'h020000});
    c18 = 1'b0;
    p17 = 1'b0;
    src.send(24'h0, 3'h2);
    wd({4'hE, 3'h2, 24'h0});
  endtask
  task automatic t_fifo;
    c18 = 1'b0;
    p17 = 1'b0;
    aud_pin_i = 4'h0;
    rdy = 1'b0;
    for (int i = 0; i < 9; i++) src.send(24'(i), 3'h2);
    chk(31'(overflow), 31'h1);
    rdy = 1'b1;
    repeat (12) @(negedge clk_sys);
    for (int i = 0; i < 8; i++) wd({4'h0, 3'h2, 24'(i)});
    chk(31'(link_valid), 31'h0);
  endtask
  initial begin
    repeat (20) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_edge();
    t_raw();
    t_filt();
    t_gpio();
    t_aud();
    t_fifo();
    conclude();
  end
endmodule // testbench
